// ==== logic/esp_core.sv ====
// status register, write protection and suspend logic of a serial eeprom
// assumes the serial pins are asynchronous and sampled by clk_i; the array
// itself lives outside and is told what to write through arr_* ports
// ==========================================================================
// Operation
// - protection active freezes select and arming bits
// - protection active when pin low and armed
// - suspend pauses serial sequence, state kept
// - suspend tied high never suspends
// - status read-only if protected or latch clear
// - bit0 busy; busy accepts only status fetch
// - latch clear blocks all modification
// - latch cleared at reset, set by command
// - select bits persistent, factory zero, always apply
// - bits 4 to 6 discarded, read zero
// - bit7 arms; pin guard skips the array
// - arming bit cannot drop while pin low
// - all status bits read one while writing
// - select code picks protected address range
// - protected range never writable; others need latch
// - latch cleared after disable, status or array write
// - status store applied only at cycle end
module esp_core
#(
  parameter int unsigned WRITE_CYC = esp_pkg::WRITE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i, // chip select pin
  input wire logic sck_i, // serial clock pin
  input wire logic si_i, // serial data in pin
  input wire logic hold_n_i, // suspend pin, active low
  input wire logic wp_n_i, // write-protect pin, active low
  output logic so_o, // serial data out
  output logic so_oe_o, // high while driving serial out
  output logic arr_we_o, // one-cycle pulse: write byte to array
  output logic [7:0] arr_addr_o, // array address for write
  output logic [7:0] arr_data_o, // array data for write
  output logic [7:0] status_o // status as the master would read it
);
  import esp_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [4:0] pins; // {cs_n, sck, si, hold_n, wp_n}
  // sck starts at its idle low level so that no false edge follows reset
  esp_sync #(.WIDTH(5), .INIT(5'h13)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
    .sync_o(pins)
  );
  logic cs_n, sck, si, hold_n, wp_n;
  assign {cs_n, sck, si, hold_n, wp_n} = pins;

  // ==========================================================================
  // protection decode
  function automatic logic in_region(input logic [1:0] sel, input logic [7:0] a);
    case (sel)
      2'h1: in_region = (a >= QUARTER_BASE);
      2'h2: in_region = (a >= HALF_BASE);
      2'h3: in_region = 1'b1;
      default: in_region = 1'b0;
    endcase
  endfunction

  logic latch; // write-enable latch
  logic [1:0] sel; // region select, persistent copy
  logic arm; // pin_guard_arm
  logic hw_prot;
  logic busy;
  logic done;
  // pin low and armed together; array never consults this
  assign hw_prot = !wp_n && arm;

  // ==========================================================================
  // serial engine state
  esp_state_t state, next_state;
  logic sck_d, next_sck_d; // previous sampled clock for edge finding
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] op, next_op;
  logic [7:0] addr, next_addr;
  logic [7:0] txreg, next_txreg;
  logic so_bit, next_so_bit;
  logic pend_latch, next_pend_latch; // latch change waits for deselect
  logic pend_val, next_pend_val;
  logic pend_stat, next_pend_stat; // status store waiting for deselect
  logic [7:0] stat_in, next_stat_in;
  logic pend_arr, next_pend_arr; // array write waiting for deselect
  logic stat_cycle, next_stat_cycle; // internal cycle belongs to status store
  logic [7:0] stat_hold, next_stat_hold;
  logic [7:0] next_latch_sel_arm;
  logic start;
  logic we, next_we;
  logic [7:0] wdata, next_wdata;
  logic [7:0] waddr, next_waddr; // address of the byte being written, held for the pulse
  logic active; // not suspended
  logic rise, fall;
  logic [7:0] status_view;
  logic [7:0] opm;

  // suspend pin held high never pauses anything
  assign active = hold_n;
  assign rise = active && sck && !sck_d;
  assign fall = active && !sck && sck_d;
  assign opm = op & OP_MASK;

  // status contents as seen by a fetch; bits 4..6 zero unless busy, all ones while busy
  assign status_view = busy ? STAT_ALL_ONES :
    {arm, 3'h0, sel, latch, 1'b0};

  // engine next-state: shift on rising edges, launch on falling
  always_comb begin
    next_state = state;
    next_sck_d = active ? sck : sck_d; // freeze edge history on suspend
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_op = op;
    next_addr = addr;
    next_txreg = txreg;
    next_so_bit = so_bit;
    next_pend_latch = pend_latch;
    next_pend_val = pend_val;
    next_pend_stat = pend_stat;
    next_stat_in = stat_in;
    next_pend_arr = pend_arr;
    next_we = 1'b0;
    next_wdata = wdata;
    next_waddr = waddr;
    if (cs_n) begin
      next_state = ESP_IDLE;
      next_bitcnt = 3'h0;
      next_pend_latch = 1'b0;
      next_pend_stat = 1'b0;
      next_pend_arr = 1'b0;
    end else if (state == ESP_IDLE) begin
      next_state = ESP_OPCODE;
    end else if (rise) begin
      next_shreg = {shreg[6:0], si};
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == 3'h7) begin
        case (state)
          ESP_OPCODE: begin
            next_op = {shreg[6:0], si};
            next_state = ESP_IGNORE;
            // while busy only a status fetch is honoured
            case ({shreg[6:0], si} & OP_MASK)
              OP_SET_LATCH: if (!busy) begin
                next_pend_latch = 1'b1;
                next_pend_val = 1'b1;
              end
              OP_CLEAR_LATCH: if (!busy) begin
                next_pend_latch = 1'b1;
                next_pend_val = 1'b0;
              end
              OP_STATUS_FETCH: begin
                next_state = ESP_DATA;
                next_txreg = status_view;
              end
              OP_STATUS_STORE: if (!busy) next_state = ESP_DATA;
              OP_ARRAY_WRITE: if (!busy) next_state = ESP_ADDR;
              default: next_state = ESP_IGNORE;
            endcase
          end
          ESP_ADDR: begin
            next_addr = {shreg[6:0], si};
            next_state = ESP_DATA;
          end
          ESP_DATA: begin
            if (opm == OP_STATUS_STORE) begin
              next_stat_in = {shreg[6:0], si};
              next_pend_stat = 1'b1;
            end else if (opm == OP_ARRAY_WRITE) begin
              next_wdata = {shreg[6:0], si};
              // protected range never written; outside needs the latch
              if (latch && !in_region(sel, addr)) begin
                next_we = 1'b1;
                next_waddr = addr; // addr itself moves on to the next byte
                next_pend_arr = 1'b1;
              end
              next_addr = {addr[7:4], addr[3:0] + 4'h1}; // page wrap
            end else begin
              next_txreg = status_view; // repeated fetch
            end
          end
          default: next_state = state;
        endcase
      end
    end else if (fall) begin
      next_so_bit = txreg[3'h7 - bitcnt];
    end
  end

  // internal write starts when the master deselects after a store or write
  assign start = cs_n && (state != ESP_IDLE) && !busy &&
    ((pend_stat && latch && !hw_prot) || pend_arr);

  // persistent bits update only at cycle end, under protection gates
  always_comb begin
    next_stat_cycle = stat_cycle;
    next_stat_hold = stat_hold;
    next_latch_sel_arm = {arm, 3'h0, sel, 1'b0, latch};
    // cycle end handled first, so a start in the same cycle wins
    if (done && stat_cycle) begin
      next_stat_cycle = 1'b0;
      // a pin lowered during the cycle still freezes the guarded bits
      // arming bit cannot fall while the pin is low
      if (!hw_prot) begin
        next_latch_sel_arm[3:2] = stat_hold[BIT_SEL_HI:BIT_SEL_LO];
        next_latch_sel_arm[BIT_ARM] = stat_hold[BIT_ARM];
      end
    end
    if (start) begin
      next_stat_cycle = pend_stat;
      next_stat_hold = stat_in;
      next_latch_sel_arm[0] = 1'b0; // cleared on store or write
    end else if (cs_n && state != ESP_IDLE && pend_latch) begin
      next_latch_sel_arm[0] = pend_val; // set only by command
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ESP_IDLE;
      sck_d <= 1'b0;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      op <= 8'h00;
      addr <= 8'h00;
      txreg <= 8'h00;
      so_bit <= 1'b0;
      pend_latch <= 1'b0;
      pend_val <= 1'b0;
      pend_stat <= 1'b0;
      stat_in <= 8'h00;
      pend_arr <= 1'b0;
      we <= 1'b0;
      wdata <= 8'h00;
      waddr <= 8'h00;
      stat_cycle <= 1'b0;
      stat_hold <= 8'h00;
      latch <= 1'b0;
      sel <= SEL_FACTORY;
      arm <= ARM_FACTORY;
    end else begin
      state <= next_state;
      sck_d <= next_sck_d;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      op <= next_op;
      addr <= next_addr;
      txreg <= next_txreg;
      so_bit <= next_so_bit;
      pend_latch <= next_pend_latch;
      pend_val <= next_pend_val;
      pend_stat <= next_pend_stat;
      stat_in <= next_stat_in;
      pend_arr <= next_pend_arr;
      we <= next_we;
      wdata <= next_wdata;
      waddr <= next_waddr;
      stat_cycle <= next_stat_cycle;
      stat_hold <= next_stat_hold;
      latch <= next_latch_sel_arm[0];
      sel <= next_latch_sel_arm[3:2];
      arm <= next_latch_sel_arm[7];
    end
  end

  // ==========================================================================
  // self-timed write cycle
  esp_timer #(.CYCLES(WRITE_CYC)) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start),
    .busy_o(busy),
    .done_o(done)
  );

  // ==========================================================================
  // outputs; serial out released while suspended or deselected
  assign so_oe_o = !cs_n && hold_n && (state == ESP_DATA) && (opm == OP_STATUS_FETCH);
  assign so_o = so_bit;
  assign arr_we_o = we;
  assign arr_addr_o = waddr;
  assign arr_data_o = wdata;
  assign status_o = status_view;

  // ==========================================================================
  // assertions
  a_prot_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!wp_n && arm) |=> (sel == $past(sel)))
    else $error("select bits changed under pin protection");
  a_arm_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(arm) && !$past(wp_n)) |-> arm)
    else $error("arming bit dropped while pin low");
  a_busy_ones: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    busy |-> (status_o == 8'hFF))
    else $error("status not all ones while busy");
  a_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !busy |-> (status_o[6:4] == 3'h0 && !status_o[0]))
    else $error("dont care bits not zero");
  a_no_prot_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_we_o |-> !in_region(sel, arr_addr_o) && latch)
    else $error("write into protected region");
  a_latch_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> !latch)
    else $error("latch not cleared at write start");
  a_store_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (busy && !done) |=> (arm == $past(arm)))
    else $error("status changed before cycle end");
  a_hold_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!hold_n && !cs_n) |-> !so_oe_o ##1 (bitcnt == $past(bitcnt)))
    else $error("activity while suspended");
endmodule

// ==== logic/esp_pkg.sv ====
// package of constants for the status register and write-protect block
// assumes a single 100 MHz system clock domain; serial pins arrive asynchronously
package esp_pkg;
  // ==========================================================================
  // status register field positions
  localparam int unsigned BIT_BUSY = 0; // ready flag, 1 while busy
  localparam int unsigned BIT_LATCH = 1; // write-enable latch
  localparam int unsigned BIT_SEL_LO = 2; // region_sel_lo
  localparam int unsigned BIT_SEL_HI = 3; // region_sel_hi
  localparam int unsigned BIT_ARM = 7; // pin_guard_arm
  localparam int unsigned STAT_W = 8; // status register width

  // ==========================================================================
  // reset and factory values
  localparam logic [1:0] SEL_FACTORY = 2'h0; // region select as delivered
  localparam logic ARM_FACTORY = 1'h0; // arming bit as delivered
  localparam logic [7:0] STAT_ALL_ONES = 8'hFF; // readback during internal write

  // ==========================================================================
  // instruction codes (bit 3 is don't care)
  localparam logic [7:0] OP_MASK = 8'hF7; // drops the don't-care bit
  localparam logic [7:0] OP_SET_LATCH = 8'h06; // set_latch_cmd
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04; // clear_latch_cmd
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05; // status_fetch_cmd
  localparam logic [7:0] OP_STATUS_STORE = 8'h01; // status_store_cmd
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02; // array write

  // ==========================================================================
  // protected region boundaries
  localparam logic [7:0] QUARTER_BASE = 8'hC0; // code 01
  localparam logic [7:0] HALF_BASE = 8'h80; // code 10

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ = 100; // system clock rate
  localparam int unsigned WRITE_TIME_MS = 4; // self-timed write cycle, max
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ; // ms to cycles

  // serial engine states
  typedef enum logic [2:0] {
    ESP_IDLE,
    ESP_OPCODE,
    ESP_ADDR,
    ESP_DATA,
    ESP_IGNORE
  } esp_state_t;
endpackage

// ==== logic/esp_sync.sv ====
// two-flop synchroniser bank for asynchronous pins
// assumes the pins are quiet levels relative to clk_i
module esp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // ==========================================================================
  // first stage feeds only the second stage
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  // stage1 loads straight from the pins, stage2 from stage1
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end
  assign sync_o = stage2;
endmodule

// ==== logic/esp_timer.sv ====
// self-timed write cycle counter
// assumes start_i is a one-cycle pulse on clk_i
module esp_timer #(
  parameter int unsigned CYCLES = 400000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  // ==========================================================================
  logic [31:0] count; // cycles left
  logic [31:0] next_count;
  logic done;
  logic next_done;
  // next-value logic: reload on start, count down to zero
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start_i) begin
      next_count = CYCLES;
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
      next_done = (count == 32'h1);
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
  assign busy_o = (count != 32'h0);
  assign done_o = done;
endmodule

// ==== tb/eeprom_status_write_protect_tb_top.sv ====
// self-checking bench for the status register and write-protect block
// assumes esp_core with a shortened write cycle and the esp_master model
module eeprom_status_write_protect_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import esp_pkg::*;

  localparam int unsigned WCYC = 400; // short write cycle keeps the run brief
  typedef struct packed {logic wp; logic [7:0] d; logic acc; logic [7:0] e;} esp_row_t;

  logic clk_i, rst_n_i, wp_n_i, cs_n, sck, si, hold_n, so, so_oe, arr_we;
  logic [7:0] arr_addr, arr_data, status, rd, a;
  logic [1:0] code;
  logic exp_we;
  int failures = 0, n_checks = 0, cyc = 0, we_cnt = 0, n0;
  logic [7:0] adrs [3] = '{8'h3F, 8'hBF, 8'hFF}; // one address in each of the three address ranges
  // store rows: pin level, data, accepted, expected view (latch masked if refused)
  esp_row_t rows [7] = '{'{1'b1, 8'hFC, 1'b1, 8'h8C}, '{1'b0, 8'h00, 1'b0, 8'h8C},
    '{1'b1, 8'h04, 1'b1, 8'h04}, '{1'b0, 8'h08, 1'b1, 8'h08},
    '{1'b0, 8'h80, 1'b1, 8'h80}, '{1'b0, 8'h00, 1'b0, 8'h80},
    '{1'b1, 8'h8C, 1'b1, 8'h8C}};

  esp_core #(.WRITE_CYC(WCYC)) esp_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
    .arr_we_o(arr_we), .arr_addr_o(arr_addr), .arr_data_o(arr_data), .status_o(status));
  esp_master esp_master_i (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si), .hold_n_o(hold_n));

  // ==========================================================================
  // clock, array pulse counter, hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (arr_we === 1'b1) we_cnt <= we_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      $display("FAIL timeout expected end seen hang");
      final_report();
    end
  end

  // ==========================================================================
  // helpers
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input int nb, input logic [7:0] b0, input logic [7:0] b1);
    esp_master_i.xfer(nb, b0, b1, 8'h00, -1, rd);
  endtask
  // wait out the write cycle, then two more cycles once ready has settled
  task automatic wait_idle();
    int k;
    k = 0;
    clks(10);
    while (status[BIT_BUSY] !== 1'b0 && k < 2000) begin
      clks(1);
      k++;
    end
    if (k == 2000) chk("ready", 8'h00, 8'h01);
    clks(2); // two more cycles after the ready edge
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    wp_n_i = 1'b1;
    clks(10);
    rst_n_i <= 1'b1;
    clks(4);
    chk("status reset", 8'h00, status);
    chk("so_oe reset", 8'h00, {7'h0, so_oe});
    send(2, OP_STATUS_STORE, 8'h8C);
    clks(100);
    chk("store no latch", 8'h00, status);
    send(3, OP_ARRAY_WRITE, 8'h10);
    chk("array no latch", 8'h00, we_cnt[7:0]);
    send(1, OP_SET_LATCH, 8'h00);
    chk("latch set", 8'h02, status);
    send(1, OP_CLEAR_LATCH, 8'h00);
    chk("latch clear", 8'h00, status);
    $display("test latch done");
    // table rows: arming, pin guard, discarded bits
    foreach (rows[r]) begin
      wp_n_i <= 1'b1;
      send(1, OP_SET_LATCH, 8'h00);
      wp_n_i <= rows[r].wp;
      send(2, OP_STATUS_STORE, rows[r].d);
      clks(10);
      if (rows[r].acc) chk("busy view", STAT_ALL_ONES, status);
      wait_idle();
      chk("status row", rows[r].e, status & (rows[r].acc ? 8'hFF : 8'hFD));
    end
    $display("test rows done");
    // suspend in the data phase of a status fetch
    wp_n_i <= 1'b1;
    esp_master_i.xfer(2, OP_STATUS_FETCH, 8'h00, 8'h00, 12, rd);
    chk("fetch held", 8'h8C, rd);
    chk("so_oe held", 8'h00, {7'h0, esp_master_i.hold_oe});
    $display("test hold done");
    // every region code against each address, pin guard armed and active
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      wp_n_i <= 1'b1;
      send(1, OP_SET_LATCH, 8'h00);
      send(2, OP_STATUS_STORE, {1'b1, 3'h0, code, 2'h0});
      wait_idle();
      wp_n_i <= 1'b0;
      foreach (adrs[j]) begin
        a = adrs[j];
        exp_we = !(code == 2'h3 || (code == 2'h2 && a >= HALF_BASE)
                   || (code == 2'h1 && a >= QUARTER_BASE));
        n0 = we_cnt;
        send(1, OP_SET_LATCH, 8'h00);
        esp_master_i.xfer(3, OP_ARRAY_WRITE, a, ~a, -1, rd);
        chk("array pulse", {7'h0, exp_we}, 8'(we_cnt - n0));
        if (exp_we) chk("array addr", a, arr_addr);
        if (exp_we) chk("array data", ~a, arr_data);
        wait_idle();
      end
    end
    $display("test regions done");
    // a latch set is ignored while busy; a fetch reads all ones
    wp_n_i <= 1'b1;
    send(1, OP_SET_LATCH, 8'h00);
    send(2, OP_STATUS_STORE, 8'h00);
    wait_idle();
    send(1, OP_SET_LATCH, 8'h00);
    n0 = we_cnt;
    esp_master_i.xfer(3, OP_ARRAY_WRITE, 8'h20, 8'h5A, -1, rd);
    send(1, OP_SET_LATCH, 8'h00);
    esp_master_i.xfer(2, OP_STATUS_FETCH, 8'h00, 8'h00, -1, rd);
    chk("fetch busy", STAT_ALL_ONES, rd);
    wait_idle();
    chk("busy refuse", 8'h00, status);
    chk("open write", 8'h01, 8'(we_cnt - n0));
    $display("test busy done");
    // second reset in mid-run clears the latch
    send(1, OP_SET_LATCH, 8'h00);
    rst_n_i <= 1'b0;
    clks(3);
    rst_n_i <= 1'b1;
    clks(4);
    chk("latch after reset", 8'h00, {6'h0, status[1:0]});
    $display("test reset again done");
    final_report();
  end
endmodule

// ==== tb/esp_master.sv ====
// spi master model (mode 0) that drives the eeprom status block pins
// assumes clk_i is the bench clock; sck runs at 8 clk_i periods, only in frames
module esp_master (
  input wire logic clk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic hold_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic hold_oe; // so_oe_i seen high while suspended

  // ==========================================================================
  // idle levels: sck stands still low between frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    hold_oe = 1'b0;
  end

  // ==========================================================================
  // suspend gap: junk on sck and si must be ignored by the device
  task automatic hold_gap();
    repeat (2) @(posedge clk_i);
    hold_n_o <= 1'b0; // moved only while sck is low
    repeat (2) begin
      repeat (4) @(posedge clk_i);
      hold_oe = hold_oe | so_oe_i;
      sck_o <= 1'b1;
      si_o <= ~si_o;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    hold_n_o <= 1'b1; // released while sck is low
    repeat (2) @(posedge clk_i);
  endtask

  // ==========================================================================
  // one frame of nb bytes, msb first; rd keeps the last byte seen on so
  task automatic xfer(input int nb, input logic [7:0] b0, input logic [7:0] b1,
                      input logic [7:0] b2, input int hold_at, output logic [7:0] rd);
    logic [23:0] v;
    v = {b0, b1, b2};
    rd = 8'h00;
    hold_oe = 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      if (i == hold_at) hold_gap();
      si_o <= v[23-i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rd = {rd[6:0], so_i};
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // si flipped after deselect, not returned to its idle low level
    repeat (8) @(posedge clk_i);
  endtask
endmodule
